// *** adc_params.svh ***
// constants for the converter reference, scan and timing control block
// assumes a 16-bit register port with word indexes, one system clock
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH

// ----------------------------------------------------------------
// register indexes
// ----------------------------------------------------------------
`define SETUP_ADDR      4'h0
`define TIMING_ADDR     4'h1
`define CTRL_ADDR       4'h2
`define CHSEL_ADDR      4'h3
`define SCAN_ADDR       4'h4
`define STATUS_ADDR     4'h5
`define MASK_ADDR       4'h6

// ----------------------------------------------------------------
// converter_setup_reg fields
// ----------------------------------------------------------------
`define REF_SEL_HI      15
`define REF_SEL_LO      13
`define OFFSET_CALIBRATION_BIT      12
`define SCAN_BIT        10
`define SPI_HI          5
`define SPI_LO          2
`define ALT_BIT         0
`define SETUP_WR_MASK   16'hf43d
`define SETUP_RESET     16'h0000

// ----------------------------------------------------------------
// converter_timing_reg fields
// ----------------------------------------------------------------
`define CLKSRC_BIT      15
`define EXTENDED_SAMPLING_FLAG_BIT      14
`define PUMP_BIT        13
`define SAMPT_HI        12
`define SAMPT_LO        8
`define DIV_HI          5
`define DIV_LO          0
`define TIMING_WR_MASK  16'hbf3f
`define TIMING_RESET    16'h0000

// ----------------------------------------------------------------
// control, channel select, interrupt registers
// ----------------------------------------------------------------
`define SAMPLE_EN_BIT   0
`define CTRL_RESET      16'h0000
`define CHA_HI          3
`define CHA_LO          0
`define CHB_HI          11
`define CHB_LO          8
`define CHSEL_WR_MASK   16'h0f0f
`define SEQ_IRQ_BIT     0
`define CONV_DONE_BIT   1
`define STATUS_MASK     16'h0003

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_NS          40
`define TCY_NS          80
`define TCY_CLKS        ((`TCY_NS + `CLK_NS - 1) / `CLK_NS)
`define CONV_TADS       12

`endif

// *** adc_pkg.sv ***
// types shared by the converter control block and its testbench
// assumes adc_params.svh holds all numeric constants
package adc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } seq_state_t;

  typedef struct packed {
    logic       we;
    logic       re;
    logic [3:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       ref_pos_ext;
    logic       ref_neg_ext;
    logic       switch_connect;
    logic       input_ground;
    logic       sample;
    logic       convert;
    logic       mux_b_active;
    logic       pump_enable;
    logic       clk_source_rc;
    logic [3:0] channel;
  } analog_ctrl_t;

endpackage : adc_pkg

// *** conv_clock_gen.sv ***
// conversion clock tick generator: system-derived divider or rc tick
// assumes rc_tick_in is already synchronous one-cycle pulses
`timescale 1ns/10ps
`include "adc_params.svh"

module conv_clock_gen (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  input  wire logic       source_rc_in,
  input  wire logic [5:0] divider_in,
  input  wire logic       rc_tick_in,
  output logic            tad_tick_out
);
  logic [7:0] count_q;
  logic [7:0] limit;

  // code n gives (n+1) instruction cycles per conversion clock
  assign limit = 8'((({2'b00, divider_in} + 8'h01) * `TCY_CLKS) - 1);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_q <= 8'h00;
    end else if (ce_in) begin
      if (source_rc_in || count_q >= limit) begin
        count_q <= 8'h00;
      end else begin
        count_q <= count_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tad_tick_out <= 1'b0;
    end else if (ce_in) begin
      tad_tick_out <= source_rc_in ? rc_tick_in : (count_q >= limit);
    end
  end

endmodule : conv_clock_gen

// *** adc_reference_scan_timing_control.sv ***
// converter reference, calibration, scan, alternate mux and timing control
// assumes a synchronous register master and an analog front end that
// follows analog_out; rc_tick_in comes from the rc oscillator, resynchronised
`timescale 1ns/10ps
`include "adc_params.svh"

// Notes on behaviour
// - reference field picks supply or external for positive and negative separately
// - calibration grounds inputs for offset conversions
// - calibration opens switches, ignores channel selection
// - scan enable steps mux a through inputs
// - interrupt every spi+1 sequences, one to sixteen
// - alternate mode: a first, then b/a
// - alternate clear: always mux a
// - unimplemented setup bits read zero
// - extended flag while sampling after enable clear
// - enable clear holds, enable set samples
// - divider field sets tad up to 64 tcy
module adc_reference_scan_timing_control
  import adc_pkg::*;
(
  input  wire logic             core_clk_in,
  input  wire logic             resetn_in,
  input  wire logic             ce_in,
  input  wire adc_pkg::reg_req_t bus_in,
  input  wire logic             rc_tick_in,
  output logic [15:0]           rdata_out,
  output adc_pkg::analog_ctrl_t analog_out,
  output logic                  irq_out
);
  import adc_pkg::*;

  // ----------------------------------------------------------------
  // reset synchroniser
  // ----------------------------------------------------------------
  logic        rst_meta_q;
  logic        rst_n;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [15:0]  setup_q;
  logic [15:0]  timing_q;
  logic [15:0]  ctrl_q;
  logic [15:0]  chsel_q;
  logic [15:0]  scan_q;
  logic [15:0]  status_q;
  logic [15:0]  status_d;
  logic [15:0]  mask_q;
  logic [15:0]  rdata_q;
  logic         irq_q;
  seq_state_t   state_q;
  logic [3:0]   tad_cnt_q;
  logic [3:0]   seq_cnt_q;
  logic [3:0]   scan_ptr_q;
  logic         alt_phase_q;
  analog_ctrl_t analog_q;
  analog_ctrl_t analog_d;
  logic         tad_tick;
  logic         conv_done;
  logic         seq_event;
  logic         ext_flag;
  logic         wr_setup;
  logic         wr_timing;
  logic [2:0]   ref_sel;
  logic         cal_mode;
  logic         scan_en;
  logic [3:0]   spi;
  logic         alt_en;
  logic         sample_en;
  logic         mux_b;

  assign ref_sel   = setup_q[`REF_SEL_HI:`REF_SEL_LO];
  assign cal_mode  = setup_q[`OFFSET_CALIBRATION_BIT];
  assign scan_en   = setup_q[`SCAN_BIT];
  assign spi       = setup_q[`SPI_HI:`SPI_LO];
  assign alt_en    = setup_q[`ALT_BIT];
  assign sample_en = ctrl_q[`SAMPLE_EN_BIT];
  assign wr_setup  = bus_in.we && bus_in.addr == `SETUP_ADDR;
  assign wr_timing = bus_in.we && bus_in.addr == `TIMING_ADDR;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // returns {positive external, negative external}
  function automatic logic [1:0] ref_decode(input logic [2:0] code);
    ref_decode = code[2] ? 2'b00 : {code[0], code[1]};
  endfunction : ref_decode

  // next set bit of the scan mask after cur, wrapping; cur if none
  function automatic logic [3:0] next_scan(input logic [15:0] mask,
                                           input logic [3:0]  cur);
    logic [3:0] c;
    logic       found;
    next_scan = cur;
    found     = 1'b0;
    c         = cur;
    for (int i = 1; i <= 16; i++) begin
      c = cur + 4'(i);
      if (mask[c] && !found) begin
        next_scan = c;
        found     = 1'b1;
      end
    end
  endfunction : next_scan

  // ----------------------------------------------------------------
  // conversion clock
  // ----------------------------------------------------------------
  conv_clock_gen u_clk_gen (
    .clk_in       (core_clk_in),
    .rst_n_in     (rst_n),
    .ce_in        (ce_in),
    .source_rc_in (timing_q[`CLKSRC_BIT]),
    .divider_in   (timing_q[`DIV_HI:`DIV_LO]),
    .rc_tick_in   (rc_tick_in),
    .tad_tick_out (tad_tick)
  );

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // only implemented bits store; reserved bit 1 and bit 7 never hold state
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      setup_q <= `SETUP_RESET;
    end else if (ce_in && wr_setup) begin
      setup_q <= bus_in.wdata & `SETUP_WR_MASK;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      timing_q <= `TIMING_RESET;
    end else if (ce_in && wr_timing) begin
      timing_q <= bus_in.wdata & `TIMING_WR_MASK;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q  <= `CTRL_RESET;
      chsel_q <= 16'h0000;
      scan_q  <= 16'h0000;
      mask_q  <= 16'h0000;
    end else if (ce_in && bus_in.we) begin
      if (bus_in.addr == `CTRL_ADDR) begin
        ctrl_q <= bus_in.wdata & 16'h0001;
      end
      if (bus_in.addr == `CHSEL_ADDR) begin
        chsel_q <= bus_in.wdata & `CHSEL_WR_MASK;
      end
      if (bus_in.addr == `SCAN_ADDR) begin
        scan_q <= bus_in.wdata;
      end
      if (bus_in.addr == `MASK_ADDR) begin
        mask_q <= bus_in.wdata & `STATUS_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // sample / convert sequencer
  // ----------------------------------------------------------------
  // sampling only ends on a conversion clock edge, so it may run on
  // after the enable is cleared; that window is the extended flag
  assign ext_flag  = state_q == ST_SAMPLE && !sample_en;
  assign conv_done = state_q == ST_CONVERT && tad_tick &&
                     tad_cnt_q == 4'(`CONV_TADS - 1);

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ST_IDLE;
      tad_cnt_q <= 4'h0;
    end else if (ce_in) begin
      unique case (state_q)
        ST_IDLE: begin
          if (sample_en) begin
            state_q <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (!sample_en && tad_tick) begin
            state_q   <= ST_CONVERT;
            tad_cnt_q <= 4'h0;
          end
        end
        ST_CONVERT: begin
          if (conv_done) begin
            state_q <= ST_IDLE;
          end else if (tad_tick) begin
            tad_cnt_q <= tad_cnt_q + 4'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sequences per interrupt
  // ----------------------------------------------------------------
  // reserved codes just stretch the count; data loss is the user's risk
  assign seq_event = conv_done && seq_cnt_q >= spi;

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      seq_cnt_q <= 4'h0;
    end else if (ce_in) begin
      if (wr_setup) begin
        seq_cnt_q <= 4'h0;
      end else if (seq_event) begin
        seq_cnt_q <= 4'h0;
      end else if (conv_done) begin
        seq_cnt_q <= seq_cnt_q + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // mux a / mux b alternation and scanning
  // ----------------------------------------------------------------
  assign mux_b = alt_en && alt_phase_q;

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      alt_phase_q <= 1'b0;
    end else if (ce_in) begin
      if (!alt_en) begin
        alt_phase_q <= 1'b0;
      end else if (conv_done) begin
        alt_phase_q <= !alt_phase_q;
      end
    end
  end

  // pointer only moves after a mux a conversion, so b samples do not skip
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      scan_ptr_q <= 4'h0;
    end else if (ce_in) begin
      if (conv_done && scan_en && !mux_b) begin
        scan_ptr_q <= next_scan(scan_q, scan_ptr_q);
      end
    end
  end

  // ----------------------------------------------------------------
  // analog front end controls
  // ----------------------------------------------------------------
  always_comb begin
    analog_d                = '0;
    {analog_d.ref_pos_ext, analog_d.ref_neg_ext} = ref_decode(ref_sel);
    analog_d.sample         = state_q == ST_SAMPLE;
    analog_d.convert        = state_q == ST_CONVERT;
    analog_d.pump_enable    = timing_q[`PUMP_BIT];
    analog_d.clk_source_rc  = timing_q[`CLKSRC_BIT];
    analog_d.mux_b_active   = mux_b;
    if (cal_mode) begin
      analog_d.switch_connect = 1'b0;
      analog_d.input_ground   = 1'b1;
      analog_d.channel        = 4'h0;
    end else begin
      analog_d.switch_connect = 1'b1;
      analog_d.input_ground   = 1'b0;
      if (mux_b) begin
        analog_d.channel = chsel_q[`CHB_HI:`CHB_LO];
      end else if (scan_en) begin
        analog_d.channel = scan_ptr_q;
      end else begin
        analog_d.channel = chsel_q[`CHA_HI:`CHA_LO];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      analog_q <= '0;
    end else if (ce_in) begin
      analog_q <= analog_d;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and output
  // ----------------------------------------------------------------
  // a new event in the clearing cycle survives: set is ORed after clear
  always_comb begin
    status_d = status_q;
    if (bus_in.we && bus_in.addr == `STATUS_ADDR) begin
      status_d = status_q & ~bus_in.wdata;
    end
    status_d[`SEQ_IRQ_BIT]   = status_d[`SEQ_IRQ_BIT] | seq_event;
    status_d[`CONV_DONE_BIT] = status_d[`CONV_DONE_BIT] | conv_done;
    status_d = status_d & `STATUS_MASK;
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 16'h0000;
      irq_q    <= 1'b0;
    end else if (ce_in) begin
      status_q <= status_d;
      irq_q    <= |(status_q & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else if (ce_in) begin
      rdata_q <= 16'h0000;
      if (bus_in.re) begin
        unique case (bus_in.addr)
          `SETUP_ADDR:  rdata_q <= setup_q & `SETUP_WR_MASK;
          `TIMING_ADDR: rdata_q <= timing_q | {1'b0, ext_flag, 14'h0000};
          `CTRL_ADDR:   rdata_q <= ctrl_q;
          `CHSEL_ADDR:  rdata_q <= chsel_q;
          `SCAN_ADDR:   rdata_q <= scan_q;
          `STATUS_ADDR: rdata_q <= status_q;
          `MASK_ADDR:   rdata_q <= mask_q;
          default:      rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  assign rdata_out  = rdata_q;
  assign analog_out = analog_q;
  assign irq_out    = irq_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n);

  a_ref_pos_decode: assert property ($past(ce_in) |->
    analog_q.ref_pos_ext == ($past(ref_sel) == 3'b001 || $past(ref_sel) == 3'b011))
    else $error("positive reference decode wrong");

  a_ref_neg_decode: assert property ($past(ce_in) |->
    analog_q.ref_neg_ext == ($past(ref_sel) == 3'b010 || $past(ref_sel) == 3'b011))
    else $error("negative reference decode wrong");

  a_cal_ground_inputs: assert property (ce_in && cal_mode |=>
    analog_q.input_ground && !analog_q.switch_connect)
    else $error("calibration did not ground inputs");

  a_cal_ignore_channel: assert property (ce_in && cal_mode |=>
    analog_q.channel == 4'h0)
    else $error("calibration followed channel selection");

  a_fixed_mux_a: assert property (ce_in && !cal_mode && !scan_en && !mux_b |=>
    analog_q.channel == $past(chsel_q[`CHA_HI:`CHA_LO]))
    else $error("mux a left fixed channel");

  a_seq_irq_every: assert property (ce_in && conv_done && spi == 4'h0 |=>
    status_q[`SEQ_IRQ_BIT])
    else $error("sequence interrupt not raised");

  a_seq_irq_second: assert property (ce_in && conv_done && spi == 4'h1 &&
    seq_cnt_q == 4'h0 && !wr_setup |=> seq_cnt_q == 4'h1)
    else $error("second sequence count wrong");

  a_alt_toggle: assert property (ce_in && alt_en && conv_done && !wr_setup |=>
    alt_phase_q != $past(alt_phase_q))
    else $error("alternate mux did not toggle");

  a_no_alt_mux_a: assert property ($past(ce_in) && !$past(alt_en) |->
    !analog_q.mux_b_active)
    else $error("mux b used with alternate off");

  a_setup_unimpl_zero: assert property (ce_in && bus_in.re &&
    bus_in.addr == `SETUP_ADDR |=> (rdata_q & ~`SETUP_WR_MASK) == 16'h0000)
    else $error("unimplemented setup bits read nonzero");

  a_ext_flag_read: assert property (ce_in && bus_in.re && bus_in.addr == `TIMING_ADDR
    |=> rdata_q[`EXTENDED_SAMPLING_FLAG_BIT] == $past(ext_flag))
    else $error("extended sampling flag read wrong");

  a_hold_in_convert: assert property ($past(ce_in) && $past(state_q) == ST_CONVERT
    |-> !analog_q.sample && analog_q.convert)
    else $error("sampling during conversion");

  c_seq_irq:    cover property (seq_event ##1 irq_q);
  c_alt_b:      cover property (conv_done && alt_en ##[1:4] analog_q.mux_b_active);
  c_cal_conv:   cover property (cal_mode && conv_done);
  c_ext_sample: cover property (ext_flag ##[1:200] state_q == ST_CONVERT);

endmodule : adc_reference_scan_timing_control

// *** rc_tick_model.sv ***
// stand-in for the rc oscillator behind the converter's rc tick input
// assumes one system clock; ticks come out as synchronous one-cycle pulses
`timescale 1ns/10ps

module rc_tick_model #(
  parameter int PERIOD = 3
) (
  input  wire logic clk_in,
  input  wire logic run_in,
  output logic      tick_out
);
  int cnt = 0;

  // stands still while run_in is low, as a stopped oscillator would
  always_ff @(posedge clk_in) begin
    if (!run_in || cnt == PERIOD - 1) cnt <= 0;
    else cnt <= cnt + 1;
  end
  assign tick_out = run_in && (cnt == PERIOD - 1);
endmodule : rc_tick_model

// *** adc_reference_scan_timing_control_tb_top.sv ***
// self-checking bench for the converter reference, scan and timing control
// assumes the register map and timing of adc_params.svh, ce_in driven here
`timescale 1ns/10ps
`include "adc_params.svh"

module adc_reference_scan_timing_control_tb_top;
  import adc_pkg::*;
  logic          clk     = 1'b0;
  logic          rst_n   = 1'b0;
  logic          rc_run  = 1'b1;
  logic          ce      = 1'b1;
  logic          rc_tick;
  reg_req_t      bus     = '0;
  logic [15:0]   rdata;
  analog_ctrl_t  ana;
  logic          irq;
  int            n_errors    = 0;
  int            check_count = 0;
  int            cyc         = 0;

  adc_reference_scan_timing_control u_adc_reference_scan_timing_control (
    .core_clk_in (clk),
    .resetn_in   (rst_n),
    .ce_in       (ce),
    .bus_in      (bus),
    .rc_tick_in  (rc_tick),
    .rdata_out   (rdata),
    .analog_out  (ana),
    .irq_out     (irq)
  );

  rc_tick_model u_rc_tick_model (
    .clk_in   (clk),
    .run_in   (rc_run),
    .tick_out (rc_tick)
  );

  initial begin
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // checks, bus cycles, closing
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  // runaway guard: every test together needs well under this
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) bus <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge clk) bus <= '0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk) bus <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk) bus <= '0;
    #1 v = rdata;
  endtask : rd

  task automatic rdchk(input string nm, input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    chk(nm, v, exp);
  endtask : rdchk

  task automatic wait_done;
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 0; i < 2000 && v[`CONV_DONE_BIT] !== 1'b1; i++) rd(`STATUS_ADDR, v);
    chk("done", {15'h0, v[`CONV_DONE_BIT]}, 16'h0001);
  endtask : wait_done

  // one sample/convert sequence; checks source during sampling and the irq after
  task automatic conv(input logic b, input logic [3:0] ch, input logic s0);
    wr(`CTRL_ADDR, 16'h0001);
    repeat (3) @(posedge clk);
    chk("sample", {15'h0, ana.sample}, 16'h0001);
    chk("mux_b", {15'h0, ana.mux_b_active}, {15'h0, b});
    chk("channel", {12'h0, ana.channel}, {12'h0, ch});
    wr(`CTRL_ADDR, 16'h0000);
    wait_done();
    chk("hold", {15'h0, ana.sample}, 16'h0000);
    rdchk("status", `STATUS_ADDR, {14'h0, 1'b1, s0});
    chk("irq", {15'h0, irq}, {15'h0, s0});
    wr(`STATUS_ADDR, 16'h0003);
    rdchk("status_clr", `STATUS_ADDR, 16'h0000);
    chk("irq_clr", {15'h0, irq}, 16'h0000);
  endtask : conv

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_scan;
    wr(`CHSEL_ADDR, 16'h0903);
    wr(`SCAN_ADDR, 16'h0025);
    wr(`MASK_ADDR, 16'h0001);
    wr(`SETUP_ADDR, 16'h0400);
    conv(1'b0, 4'h0, 1'b1);
    conv(1'b0, 4'h2, 1'b1);
    conv(1'b0, 4'h5, 1'b1);
    wr(`SETUP_ADDR, 16'h0000);
    conv(1'b0, 4'h3, 1'b1);
    conv(1'b0, 4'h3, 1'b1);
    $display("test scan done");
  endtask : t_scan

  task automatic t_irq_alt;
    wr(`SETUP_ADDR, 16'h0004);
    conv(1'b0, 4'h3, 1'b0);
    conv(1'b0, 4'h3, 1'b1);
    wr(`SETUP_ADDR, 16'h0001);
    conv(1'b0, 4'h3, 1'b1);
    conv(1'b1, 4'h9, 1'b1);
    conv(1'b0, 4'h3, 1'b1);
    wr(`MASK_ADDR, 16'h0000);
    wr(`SETUP_ADDR, 16'h0000);
    wr(`CTRL_ADDR, 16'h0001);
    wr(`CTRL_ADDR, 16'h0000);
    wait_done();
    chk("irq_masked", {15'h0, irq}, 16'h0000);
    wr(`STATUS_ADDR, 16'h0003);
    $display("test irq and alternate done");
  endtask : t_irq_alt

  task automatic t_regs;
    logic [2:0]  c;
    logic [15:0] v;
    rd(`SETUP_ADDR, v);
    chk("setup_rst", v & 16'hff7f, `SETUP_RESET);
    rdchk("timing_rst", `TIMING_ADDR, `TIMING_RESET);
    // reserved bits 6, 8, 9 and 11 stay zero and the interval code stays legal
    wr(`SETUP_ADDR, 16'hffc5);
    rd(`SETUP_ADDR, v);
    chk("setup_mask", v & 16'hff7f, 16'hf405);
    rdchk("unmapped", 4'hf, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      wr(`SETUP_ADDR, {c, 13'h0000});
      repeat (2) @(posedge clk);
      chk("ref", {14'h0, ana.ref_pos_ext, ana.ref_neg_ext},
          {14'h0, (c[2] ? 2'b00 : {c[0], c[1]})});
    end
    wr(`SETUP_ADDR, 16'h1000);
    repeat (2) @(posedge clk);
    chk("ground", {14'h0, ana.input_ground, ana.switch_connect}, 16'h0002);
    chk("cal_ch", {12'h0, ana.channel}, 16'h0000);
    wr(`SETUP_ADDR, 16'h0000);
    repeat (2) @(posedge clk);
    chk("unground", {15'h0, ana.input_ground}, 16'h0000);
    // a write while the enable is low must leave no trace
    ce <= 1'b0;
    wr(`MASK_ADDR, 16'h0003);
    ce <= 1'b1;
    rdchk("ce_freeze", `MASK_ADDR, 16'h0000);
    $display("test registers done");
  endtask : t_regs

  task automatic t_timing;
    wr(`TIMING_ADDR, 16'hffff);
    rdchk("timing_mask", `TIMING_ADDR, 16'hbf3f);
    wr(`TIMING_ADDR, 16'h003f);
    wr(`CTRL_ADDR, 16'h0001);
    repeat (3) @(posedge clk);
    wr(`CTRL_ADDR, 16'h0000);
    rdchk("ext_on", `TIMING_ADDR, 16'h403f);
    // slowest divider: 128 clocks per tick, conversion ends near 1650 clocks
    repeat (200) @(posedge clk);
    chk("convert", {14'h0, ana.sample, ana.convert}, 16'h0001);
    repeat (1200) @(posedge clk);
    rdchk("div_slow", `STATUS_ADDR, 16'h0000);
    wait_done();
    rdchk("ext_off", `TIMING_ADDR, 16'h003f);
    wr(`STATUS_ADDR, 16'h0003);
    rc_run <= 1'b0;
    wr(`TIMING_ADDR, 16'ha000);
    repeat (2) @(posedge clk);
    chk("rc_src", {14'h0, ana.clk_source_rc, ana.pump_enable}, 16'h0003);
    wr(`CTRL_ADDR, 16'h0001);
    wr(`CTRL_ADDR, 16'h0000);
    repeat (200) @(posedge clk);
    rdchk("rc_stopped", `STATUS_ADDR, 16'h0000);
    rc_run <= 1'b1;
    wait_done();
    wr(`STATUS_ADDR, 16'h0003);
    wr(`TIMING_ADDR, 16'h0000);
    $display("test timing done");
  endtask : t_timing

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_scan();
    t_irq_alt();
    t_regs();
    t_timing();
    test_done();
  end
endmodule : adc_reference_scan_timing_control_tb_top
